// ### inc/secp_pkg.sv
package secp_pkg;

  // ==========================================================
  // Line format and timing
  // ==========================================================
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned STOP_BITS     = 1;
  localparam int unsigned GAP_TIME_US   = 1000;
  localparam int unsigned GAP_CYCLES    = GAP_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0]  CHAR_NEWLINE  = 8'h0A;
  localparam int unsigned LINE_DEPTH    = 64;
  localparam logic        LINE_IDLE     = 1'b1;

  // ==========================================================
  // Port states
  // ==========================================================
  typedef enum logic [3:0] {
    SECP_IDLE = 4'b0001,
    SECP_ECHO = 4'b0010,
    SECP_EXEC = 4'b0100,
    SECP_RESP = 4'b1000
  } secp_state_t;

endpackage

// ### design/secp_uart_rx.sv
`timescale 1ns/1ps
module secp_uart_rx #(
  parameter int unsigned BIT_CYC = 10416
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       rxd_sync,
  output logic            valid_r,
  output logic [7:0]      data_r
);
  import secp_pkg::*;

  initial
  begin
    // The bit counter is 16 bits wide, so longer bit periods cannot be served.
    if (BIT_CYC < 4 || BIT_CYC > 65536)
      $error("Bit period too short.");
  end

  logic        busy_r;
  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;

  wire         cnt_done = (cnt_r == 16'h0000);
  wire [15:0]  half_cyc = 16'((BIT_CYC / 2) - 1);
  wire [15:0]  full_cyc = 16'(BIT_CYC - 1);

  // Start detected on a falling idle line, sampled mid-bit, LSB first.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r  <= 1'b0;
      cnt_r   <= 16'h0000;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      valid_r <= 1'b0;
      data_r  <= 8'h00;
    end
    else if (ce)
    begin
      valid_r <= 1'b0;
      if (!busy_r)
      begin
        if (!rxd_sync)
        begin
          busy_r <= 1'b1;
          cnt_r  <= half_cyc;
          bit_r  <= 4'h0;
        end
      end
      else if (!cnt_done)
        cnt_r <= cnt_r - 16'h0001;
      else
      begin
        cnt_r <= full_cyc;
        bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h0 && rxd_sync)
          busy_r <= 1'b0;
        else if (bit_r >= 4'h1 && bit_r <= 4'h8)
          sh_r <= {rxd_sync, sh_r[7:1]};
        else if (bit_r == 4'h9)
        begin
          busy_r <= 1'b0;
          if (rxd_sync)
          begin
            valid_r <= 1'b1;
            data_r  <= sh_r;
          end
        end
      end
    end
  end

endmodule

// ### design/secp_uart_tx.sv
`timescale 1ns/1ps
module secp_uart_tx #(
  parameter int unsigned BIT_CYC = 10416
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            busy_r,
  output logic            txd_r
);
  import secp_pkg::*;

  initial
  begin
    if (BIT_CYC < 2 || BIT_CYC > 65536)
      $error("Bit period too short.");
  end

  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic [9:0]  sh_r;

  wire [15:0]  full_cyc = 16'(BIT_CYC - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      cnt_r  <= 16'h0000;
      bit_r  <= 4'h0;
      sh_r   <= 10'h3FF;
      txd_r  <= LINE_IDLE;
    end
    else if (ce)
    begin
      if (!busy_r)
      begin
        txd_r <= LINE_IDLE;
        if (start)
        begin
          busy_r <= 1'b1;
          sh_r   <= {1'b1, data, 1'b0};
          cnt_r  <= 16'h0000;
          bit_r  <= 4'h0;
        end
      end
      else if (cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
      else if (bit_r == 4'hA)
        busy_r <= 1'b0;
      else
      begin
        txd_r <= sh_r[0];
        sh_r  <= {1'b1, sh_r[9:1]};
        bit_r <= bit_r + 4'h1;
        cnt_r <= full_cyc;
      end
    end
  end

endmodule

// ### design/secp_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Only TXD and RXD lines, no handshake
// - 9600 baud, 8 data, 1 stop, none parity
// - Newline code 10 ends commands and responses
// - Execute command only after newline received
// - Echo every accepted character unchanged
// - Discard and do not echo during execution
// - Transmit only echoes or query responses
// - Send query response as soon as recognised
// - Responses are ASCII ending in newline
// - Successive responses separated by 1 ms gaps
// - Active only when enabled, not transmit-only
// - Each immediate trigger starts one measurement
module secp_top #(
  parameter int unsigned BIT_CYC = secp_pkg::BIT_CYCLES,
  parameter int unsigned GAP_CYC = secp_pkg::GAP_CYCLES
) (
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic       CLK_EN,
  input  wire logic       RXD,
  output logic            TXD,
  input  wire logic       SERIAL_ENABLE,
  input  wire logic       TRANSMIT_ONLY_MODE,
  input  wire logic       TRIGGERED_MODE,
  output logic            CMD_VALID,
  output logic [7:0]      CMD_BYTE,
  output logic            CMD_END,
  input  wire logic       CMD_IS_QUERY,
  input  wire logic       CMD_IS_TRIGGER,
  input  wire logic       CMD_DONE,
  input  wire logic       RESP_VALID,
  input  wire logic [7:0] RESP_BYTE,
  input  wire logic       RESP_LAST,
  output logic            RESP_READY,
  output logic            MEAS_START,
  output logic            EXECUTING
);
  import secp_pkg::*;

  initial
  begin
    if (GAP_CYC < 1 || BIT_CYC < 4 || BIT_CYC > 65536)
      $error("Timing parameters out of range.");
  end

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  logic rxd_meta_r;
  logic rxd_sync_r;
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rxd_meta_r <= LINE_IDLE;
      rxd_sync_r <= LINE_IDLE;
    end
    else if (CLK_EN)
    begin
      rxd_meta_r <= RXD;
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // ==========================================================
  // Serial engines
  // ==========================================================
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_busy;
  logic       tx_line;
  logic       tx_start;
  logic [7:0] tx_data;

  secp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .ce       (CLK_EN),
    .rxd_sync (rxd_sync_r),
    .valid_r  (rx_valid),
    .data_r   (rx_data)
  );

  secp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk    (MCLK),
    .rst_n  (RESET_N),
    .ce     (CLK_EN),
    .start  (tx_start),
    .data   (tx_data),
    .busy_r (tx_busy),
    .txd_r  (tx_line)
  );

  // ==========================================================
  // Command and response sequencing
  // ==========================================================
  secp_state_t state_r;
  secp_state_t state_nxt;
  logic [7:0]  echo_r;
  logic        echo_nl_r;
  logic        launched_r;
  logic [31:0] gap_r;
  logic        resp_last_r;
  logic        trig_seen_r;

  wire port_on    = SERIAL_ENABLE && !TRANSMIT_ONLY_MODE;
  wire accept     = (state_r == SECP_IDLE) && rx_valid && port_on;
  wire gap_clear  = (gap_r == 32'h0000_0000);
  wire resp_take  = (state_r == SECP_RESP) && RESP_VALID && !tx_busy && !launched_r
                    && gap_clear && port_on;
  wire echo_go    = (state_r == SECP_ECHO) && !tx_busy && !launched_r;
  wire echo_sent  = (state_r == SECP_ECHO) && launched_r && !tx_busy;
  wire resp_sent  = (state_r == SECP_RESP) && launched_r && !tx_busy;

  // Transmit only from an echo or a response byte.
  assign tx_start = echo_go || resp_take;
  assign tx_data  = echo_go ? echo_r : RESP_BYTE;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SECP_IDLE:
        if (accept)
          state_nxt = SECP_ECHO;
      SECP_ECHO:
        if (echo_sent)
          state_nxt = echo_nl_r ? SECP_EXEC : SECP_IDLE;
      SECP_EXEC:
        if (CMD_DONE)
          state_nxt = SECP_IDLE;
        else if (CMD_IS_QUERY)
          state_nxt = SECP_RESP;
      SECP_RESP:
        if (resp_sent && resp_last_r)
          state_nxt = SECP_EXEC;
        else if (!port_on)
          state_nxt = SECP_EXEC;
      default:
        state_nxt = SECP_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r     <= SECP_IDLE;
      echo_r      <= 8'h00;
      echo_nl_r   <= 1'b0;
      launched_r  <= 1'b0;
      resp_last_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_r <= state_nxt;
      if (accept)
      begin
        echo_r    <= rx_data;
        echo_nl_r <= (rx_data == CHAR_NEWLINE);
      end
      if (tx_start)
        launched_r <= 1'b1;
      else if (echo_sent || resp_sent)
        launched_r <= 1'b0;
      if (resp_take)
        resp_last_r <= RESP_LAST;
    end
  end

  // A gap is held after each finished response before the next one starts.
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      gap_r <= 32'h0000_0000;
    else if (CLK_EN)
    begin
      // Unread response data is lost, so the gap is never shortened.
      if (resp_sent && resp_last_r)
        gap_r <= 32'(GAP_CYC);
      else if (!gap_clear)
        gap_r <= gap_r - 32'h0000_0001;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      TXD        <= LINE_IDLE;
      CMD_VALID  <= 1'b0;
      CMD_BYTE   <= 8'h00;
      CMD_END    <= 1'b0;
      RESP_READY <= 1'b0;
      MEAS_START <= 1'b0;
      EXECUTING  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      TXD        <= tx_line;
      CMD_VALID  <= echo_sent;
      CMD_BYTE   <= echo_r;
      CMD_END    <= echo_sent && echo_nl_r;
      RESP_READY <= resp_take;
      // Only the first SECP_EXEC cycle with CMD_IS_TRIGGER high can trigger, so one command gives one shot.
      MEAS_START <= (state_r == SECP_EXEC) && CMD_IS_TRIGGER && TRIGGERED_MODE
                    && !trig_seen_r;
      EXECUTING  <= (state_nxt == SECP_EXEC) || (state_nxt == SECP_RESP);
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      trig_seen_r <= 1'b0;
    else if (CLK_EN)
    begin
      if (state_r != SECP_EXEC && state_r != SECP_RESP)
        trig_seen_r <= 1'b0;
      else if (state_r == SECP_EXEC && CMD_IS_TRIGGER)
        trig_seen_r <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  rx_dropped_exec_a: assert property (
    (CLK_EN && rx_valid && state_r == SECP_EXEC) |=> state_r != SECP_ECHO)
    else $error("Character accepted during execution.");
  no_echo_off_a: assert property (
    (CLK_EN && !port_on) |-> !accept)
    else $error("Character accepted while port off.");
  echo_value_a: assert property (
    (CLK_EN && accept) |=> echo_r == $past(rx_data))
    else $error("Echo byte differs from received byte.");
  newline_exec_a: assert property (
    (CLK_EN && echo_sent && echo_nl_r) |=> state_r == SECP_EXEC)
    else $error("Newline did not start execution.");
  plain_no_exec_a: assert property (
    (CLK_EN && echo_sent && !echo_nl_r) |=> state_r == SECP_IDLE)
    else $error("Execution began without newline.");
  tx_cause_a: assert property (
    tx_start |-> (state_r == SECP_ECHO || state_r == SECP_RESP))
    else $error("Transmit without echo or response.");
  resp_gap_a: assert property (
    (CLK_EN && resp_sent && resp_last_r) |=> gap_r == 32'(GAP_CYC))
    else $error("Response gap not loaded.");
  trig_once_a: assert property (
    MEAS_START |=> !MEAS_START)
    else $error("Trigger started more than one measurement.");
  idle_high_a: assert property (
    (!tx_busy && !$past(tx_busy)) |-> tx_line)
    else $error("Line not idle high.");
  start_bit_a: assert property (
    (CLK_EN && tx_start) |=> ##1 !tx_line)
    else $error("Frame did not open with a low start bit.");
  resp_ready_a: assert property (
    (CLK_EN && resp_take) |=> RESP_READY)
    else $error("Response byte taken without ready pulse.");
  cmd_end_a: assert property (
    CMD_END |-> (CMD_VALID && CMD_BYTE == CHAR_NEWLINE))
    else $error("Command end without newline byte.");
  resp_off_a: assert property (
    (CLK_EN && !port_on) |-> !resp_take)
    else $error("Response sent while port off.");
  exec_flag_a: assert property (
    ($past(CLK_EN) && (state_r == SECP_EXEC || state_r == SECP_RESP)) |-> EXECUTING)
    else $error("Execution not flagged.");

  echo_cov_c: cover property (CLK_EN && echo_sent);
  exec_cov_c: cover property (CLK_EN && echo_sent && echo_nl_r);
  resp_cov_c: cover property (CLK_EN && resp_sent && resp_last_r);
  trig_cov_c: cover property (MEAS_START);
  off_cov_c: cover property (CLK_EN && !port_on && rx_valid);

endmodule

// ### dv/secp_host.sv
`timescale 1ns/1ps
module secp_host #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic       clk,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            got_valid,
  output logic [7:0]      got_byte
);
  // ==========================================================
  // Sending side
  // ==========================================================
  initial line_out = 1'b1;

  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= fr[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask

  // ==========================================================
  // Receiving side
  // ==========================================================
  // The receiver never pauses, so no echo or response is missed.
  initial
  begin
    got_valid = 1'b0;
    got_byte  = 8'h00;
    forever
    begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        got_byte[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk);
      // A low stop bit drops the byte, which then shows as a missing echo.
      got_valid <= line_in;
      @(posedge clk);
      got_valid <= 1'b0;
    end
  end
endmodule

// ### dv/secp_top_tb.sv
`timescale 1ns/1ps
module secp_top_tb;
  import secp_pkg::*;
  localparam int unsigned BC = 16;
  localparam int unsigned GC = 20;
  logic       MCLK;
  logic       RESET_N;
  logic       RXD;
  logic       TXD;
  logic       SERIAL_ENABLE;
  logic       TRANSMIT_ONLY_MODE;
  logic       TRIGGERED_MODE;
  logic       CMD_VALID;
  logic [7:0] CMD_BYTE;
  logic       CMD_END;
  logic       CMD_IS_QUERY;
  logic       CMD_IS_TRIGGER;
  logic       CMD_DONE;
  logic       RESP_VALID;
  logic [7:0] RESP_BYTE;
  logic       RESP_LAST;
  logic       RESP_READY;
  logic       MEAS_START;
  logic       EXECUTING;
  logic       got_valid;
  logic [7:0] got_byte;
  logic [7:0] echo_q[$];
  logic [8:0] cmd_q[$];
  int         failures;
  int         checks_done;
  int         cyc;
  int         meas_cnt;
  int         m0;
  integer     seed;
  time        t_rdy;

  secp_top #(
    .BIT_CYC (BC),
    .GAP_CYC (GC)
  ) u_secp_top (
    .MCLK               (MCLK),
    .RESET_N            (RESET_N),
    .CLK_EN             (1'b1),
    .RXD                (RXD),
    .TXD                (TXD),
    .SERIAL_ENABLE      (SERIAL_ENABLE),
    .TRANSMIT_ONLY_MODE (TRANSMIT_ONLY_MODE),
    .TRIGGERED_MODE     (TRIGGERED_MODE),
    .CMD_VALID          (CMD_VALID),
    .CMD_BYTE           (CMD_BYTE),
    .CMD_END            (CMD_END),
    .CMD_IS_QUERY       (CMD_IS_QUERY),
    .CMD_IS_TRIGGER     (CMD_IS_TRIGGER),
    .CMD_DONE           (CMD_DONE),
    .RESP_VALID         (RESP_VALID),
    .RESP_BYTE          (RESP_BYTE),
    .RESP_LAST          (RESP_LAST),
    .RESP_READY         (RESP_READY),
    .MEAS_START         (MEAS_START),
    .EXECUTING          (EXECUTING)
  );

  secp_host #(
    .BIT_CYC (BC)
  ) u_secp_host (
    .clk       (MCLK),
    .line_in   (TXD),
    .line_out  (RXD),
    .got_valid (got_valid),
    .got_byte  (got_byte)
  );

  // ==========================================================
  // Checking and closing
  // ==========================================================
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Outputs are looked at on the falling edge, where they have settled.
  always @(negedge MCLK)
  begin
    cyc++;
    if (MEAS_START === 1'b1)
      meas_cnt++;
    if (got_valid === 1'b1)
    begin
      if (echo_q.size() == 0)
        check(9'h100, 9'h000);
      else
        check({1'b0, got_byte}, {1'b0, echo_q.pop_front()});
    end
    if (CMD_VALID === 1'b1)
    begin
      if (cmd_q.size() == 0)
        check(9'h100, 9'h000);
      else
        check({CMD_END, CMD_BYTE}, cmd_q.pop_front());
    end
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // Drivers
  // ==========================================================
  function automatic logic [7:0] rch();
    logic [31:0] r;
    r = $random(seed);
    rch = {2'b01, r[5:0]};
  endfunction

  task automatic send_ch(input logic [7:0] b, input logic ok);
    int n;
    if (ok)
    begin
      echo_q.push_back(b);
      cmd_q.push_back({b == CHAR_NEWLINE, b});
    end
    @(posedge MCLK);
    u_secp_host.send(b);
    n = 0;
    while ((echo_q.size() + cmd_q.size() > 0 || !ok) && n < 400)
    begin
      @(negedge MCLK);
      n++;
    end
    if (ok)
      check({8'h00, n < 400}, 9'h001);
    @(posedge MCLK);
  endtask

  task automatic resp(input logic [7:0] b, input logic last, input logic fin, input logic gap);
    int n;
    echo_q.push_back(b);
    RESP_VALID <= 1'b1;
    RESP_BYTE  <= b;
    RESP_LAST  <= last;
    if (fin)
      CMD_IS_QUERY <= 1'b0;
    n = 0;
    @(negedge MCLK);
    while (RESP_READY !== 1'b1 && n < 2000)
    begin
      @(negedge MCLK);
      n++;
    end
    check({8'h00, n < 2000}, 9'h001);
    if (gap)
      check({8'h00, ($time - t_rdy) / 10 >= 10 * BC + GC}, 9'h001);
    t_rdy = $time;
    @(posedge MCLK);
    RESP_VALID <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic done;
    int n;
    // A response still on the line keeps the port busy, so let it finish first.
    n = 0;
    while (echo_q.size() > 0 && n < 400)
    begin
      @(negedge MCLK);
      n++;
    end
    repeat (BC) @(posedge MCLK);
    CMD_DONE <= 1'b1;
    @(posedge MCLK);
    CMD_DONE <= 1'b0;
    repeat (2) @(negedge MCLK);
    check({8'h00, EXECUTING}, 9'h000);
    @(posedge MCLK);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    seed = 13;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    meas_cnt = 0;
    t_rdy = 0;
    RESET_N = 1'b0;
    SERIAL_ENABLE = 1'b1;
    TRANSMIT_ONLY_MODE = 1'b0;
    TRIGGERED_MODE = 1'b0;
    CMD_IS_QUERY = 1'b0;
    CMD_IS_TRIGGER = 1'b0;
    CMD_DONE = 1'b0;
    RESP_VALID = 1'b0;
    RESP_BYTE = 8'h00;
    RESP_LAST = 1'b0;
    repeat (12) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (3) @(negedge MCLK);
    check({4'h0, TXD, EXECUTING, CMD_VALID, RESP_READY, MEAS_START}, 9'h010);
    for (int i = 0; i < 3; i++)
      send_ch(rch(), 1'b1);
    check({8'h00, EXECUTING}, 9'h000);
    send_ch(CHAR_NEWLINE, 1'b1);
    check({8'h00, EXECUTING}, 9'h001);
    send_ch(8'h5A, 1'b0);
    done();
    send_ch(8'h5A, 1'b1);
    send_ch(CHAR_NEWLINE, 1'b1);
    done();
    CMD_IS_QUERY <= 1'b1;
    send_ch(8'h3F, 1'b1);
    send_ch(CHAR_NEWLINE, 1'b1);
    resp(8'h31, 1'b0, 1'b0, 1'b0);
    resp(CHAR_NEWLINE, 1'b1, 1'b0, 1'b0);
    resp(8'h32, 1'b0, 1'b0, 1'b1);
    resp(CHAR_NEWLINE, 1'b1, 1'b1, 1'b0);
    done();
    TRIGGERED_MODE <= 1'b1;
    CMD_IS_TRIGGER <= 1'b1;
    m0 = meas_cnt;
    send_ch(rch(), 1'b1);
    send_ch(CHAR_NEWLINE, 1'b1);
    repeat (50) @(negedge MCLK);
    check(9'(meas_cnt - m0), 9'h001);
    CMD_IS_TRIGGER <= 1'b0;
    done();
    TRANSMIT_ONLY_MODE <= 1'b1;
    send_ch(rch(), 1'b0);
    TRANSMIT_ONLY_MODE <= 1'b0;
    SERIAL_ENABLE <= 1'b0;
    send_ch(rch(), 1'b0);
    SERIAL_ENABLE <= 1'b1;
    send_ch(rch(), 1'b1);
    end_sim();
  end
endmodule
